// ==== rtl/lcc_cmd_decoder.sv ====
// LCD controller host interface, command decoder and address state
`default_nettype none
module lcc_cmd_decoder
  import lcc_pkg::*;
#(
  parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hardware_reset_n,
  // Host bus
  input wire logic [1:0] bus_mode,
  input wire logic cs_n,
  input wire logic reg_select,
  input wire logic rd_e,
  input wire logic wr_rw,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Serial link
  input wire logic sclk,
  input wire logic sdata,
  // Display RAM port
  input wire logic ram_ready,
  input wire logic [DATA_W-1:0] ram_rdata,
  output logic [PAGE_W-1:0] ram_page,
  output logic [COL_W-1:0] ram_col,
  output logic [DATA_W-1:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  // Display control state
  output logic display_on,
  output logic seg_reverse,
  output logic reverse_video,
  output logic all_on,
  output logic bias_sel,
  output logic power_save,
  output logic [LINE_W-1:0] start_line,
  output logic [PAGE_W-1:0] page,
  output logic [COL_W-1:0] column,
  output logic rmw_active,
  // Status
  output logic busy,
  output logic reset_active
);
  typedef struct packed {
    logic rd_q;
    logic wr_q;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic display_on;
    logic seg_reverse;
    logic reverse_video;
    logic all_on;
    logic bias_sel;
    logic power_save;
    logic [LINE_W-1:0] start_line;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] col_saved;
    logic rmw;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic reset_active;
    logic busy;
    logic [PAGE_W-1:0] ram_page;
    logic [COL_W-1:0] ram_col;
    logic [DATA_W-1:0] ram_wdata;
    logic ram_we;
    logic ram_re;
    logic rd_pend;
    logic [DATA_W-1:0] read_latch;
  } lcc_state_t;

  lcc_state_t q;
  lcc_state_t next_q;

  // Bus event decode
  logic parallel;
  logic selected;
  logic wr_done;
  logic rd_done;
  logic rd_active;
  logic [DATA_W-1:0] status;

  // Serial receiver outputs
  logic ser_valid;
  logic ser_rs;
  logic [DATA_W-1:0] ser_byte;

  // Queue signals
  logic host_valid;
  logic [WORD_W-1:0] host_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [WORD_W-1:0] fifo_word;
  logic exec;
  logic [DATA_W-1:0] cmd;

  assign parallel = bus_mode != MODE_SERIAL;
  assign selected = !cs_n;

  always_comb
  begin
    if (bus_mode == MODE_6800)
    begin
      // Enable high pulse, read/write level selects direction
      wr_done = q.rd_q && !rd_e && !wr_rw;
      rd_done = q.rd_q && !rd_e && wr_rw;
      rd_active = rd_e && wr_rw;
    end
    else
    begin
      // Separate active low read and write strobes
      wr_done = !q.wr_q && wr_rw;
      rd_done = !q.rd_q && rd_e;
      rd_active = !rd_e;
    end
  end

  // Status byte, low nibble zero
  assign status = {q.busy, !q.seg_reverse, !q.display_on, q.reset_active, 4'h0};

  lcc_serial_rx u_serial (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(bus_mode == MODE_SERIAL),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdata(sdata),
    .reg_select(reg_select),
    .byte_valid(ser_valid),
    .byte_rs(ser_rs),
    .byte_data(ser_byte)
  );

  // Writes of both kinds and data reads are queued; status reads are not
  always_comb
  begin
    if (parallel)
    begin
      host_valid = selected && (wr_done || (rd_done && reg_select));
      host_word = {rd_done, reg_select, data_in};
    end
    else
    begin
      host_valid = ser_valid;
      host_word = {1'b0, ser_rs, ser_byte};
    end
  end

  lcc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .in_valid(host_valid && !q.busy),
    .in_ready(fifo_in_ready),
    .in_data(host_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_word)
  );

  // RAM contention and initialisation stall the executor
  assign fifo_out_ready = ram_ready && !q.reset_active && hardware_reset_n;
  assign exec = fifo_out_valid && fifo_out_ready;
  assign cmd = fifo_word[DATA_W-1:0];

  always_comb
  begin
    next_q = q;
    next_q.rd_q = rd_e;
    next_q.wr_q = wr_rw;
    next_q.ram_we = 1'b0;
    next_q.ram_re = 1'b0;
    next_q.rd_pend = q.ram_re;
    if (q.rd_pend)
      next_q.read_latch = ram_rdata;
    // Read buffer lags one access behind the column
    next_q.data_out = reg_select ? q.read_latch : status;
    next_q.data_oe = parallel && selected && rd_active;

    if (q.reset_active)
    begin
      if (q.rst_cnt == RST_CNT_ZERO)
        next_q.reset_active = 1'b0;
      else
        next_q.rst_cnt = q.rst_cnt - RST_CNT_W'(1);
    end

    if (exec)
    begin
      if (fifo_word[WD_RS])
      begin
        next_q.ram_page = q.page;
        next_q.ram_col = q.col;
        if (fifo_word[WD_READ])
        begin
          next_q.ram_re = 1'b1;
          if (!q.rmw && q.col != COL_LIMIT)
            next_q.col = q.col + COL_W'(1);
        end
        else
        begin
          next_q.ram_we = 1'b1;
          if (q.page == PAGE_INDICATOR)
            next_q.ram_wdata = {7'h00, cmd[0]};
          else
            next_q.ram_wdata = cmd;
          if (q.col != COL_LIMIT)
            next_q.col = q.col + COL_W'(1);
        end
      end
      else if (!fifo_word[WD_READ])
      begin
        if (cmd[7:1] == CMD_DISP_ONOFF)
          next_q.display_on = cmd[0];
        else if (cmd[7:1] == CMD_SEG_ORDER)
          next_q.seg_reverse = cmd[0];
        else if (cmd[7:1] == CMD_POLARITY)
          next_q.reverse_video = cmd[0];
        else if (cmd[7:1] == CMD_ALL_ON)
          next_q.all_on = cmd[0];
        else if (cmd[7:1] == CMD_BIAS)
          next_q.bias_sel = cmd[0];
        else if (cmd[7:6] == CMD_START_LINE)
          next_q.start_line = cmd[LINE_W-1:0];
        else if (cmd[7:4] == CMD_PAGE)
        begin
          if (cmd[3:0] <= PAGE_INDICATOR)
            next_q.page = cmd[3:0];
        end
        else if (cmd[7:4] == CMD_COL_HI)
          next_q.col = {cmd[3:0], q.col[3:0]};
        else if (cmd[7:4] == CMD_COL_LO)
          next_q.col = {q.col[7:4], cmd[3:0]};
        else if (cmd == CMD_RMW)
        begin
          next_q.rmw = 1'b1;
          next_q.col_saved = q.col;
        end
        else if (cmd == CMD_END)
        begin
          next_q.rmw = 1'b0;
          if (q.rmw)
            next_q.col = q.col_saved;
        end
        else if (cmd == CMD_RESET)
        begin
          next_q.start_line = '0;
          next_q.col = '0;
          next_q.page = '0;
          next_q.rmw = 1'b0;
          next_q.reset_active = 1'b1;
          next_q.rst_cnt = RST_CNT_INIT;
        end
        // Any other byte leaves all state alone
        else
          next_q.rmw = q.rmw;
      end
    end

    // Pin reset re-initialises control state and holds the counter
    if (!hardware_reset_n)
    begin
      next_q.display_on = 1'b0;
      next_q.seg_reverse = 1'b0;
      next_q.reverse_video = 1'b0;
      next_q.all_on = 1'b0;
      next_q.bias_sel = 1'b0;
      next_q.start_line = '0;
      next_q.page = '0;
      next_q.col = '0;
      next_q.rmw = 1'b0;
      next_q.ram_we = 1'b0;
      next_q.ram_re = 1'b0;
      next_q.reset_active = 1'b1;
      next_q.rst_cnt = RST_CNT_INIT;
    end

    next_q.power_save = next_q.all_on && !next_q.display_on;
    // Busy while initialising or while the queue is full
    next_q.busy = next_q.reset_active || !fifo_in_ready;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.rd_q <= 1'b1;
      q.wr_q <= 1'b1;
      q.reset_active <= 1'b1;
      q.busy <= 1'b1;
      q.rst_cnt <= RST_CNT_INIT;
    end
    else if (ce)
      q <= next_q;
  end

  assign data_out = q.data_out;
  assign data_oe = q.data_oe;
  assign ram_page = q.ram_page;
  assign ram_col = q.ram_col;
  assign ram_wdata = q.ram_wdata;
  assign ram_we = q.ram_we;
  assign ram_re = q.ram_re;
  assign display_on = q.display_on;
  assign seg_reverse = q.seg_reverse;
  assign reverse_video = q.reverse_video;
  assign all_on = q.all_on;
  assign bias_sel = q.bias_sel;
  assign power_save = q.power_save;
  assign start_line = q.start_line;
  assign page = q.page;
  assign column = q.col;
  assign rmw_active = q.rmw;
  assign busy = q.busy;
  assign reset_active = q.reset_active;
endmodule : lcc_cmd_decoder
`default_nettype wire

// ==== rtl/lcc_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module lcc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
  } lcc_fifo_t;

  lcc_fifo_t q;
  lcc_fifo_t next_q;
  logic full;
  logic empty;

  assign empty = q.wr_ptr == q.rd_ptr;
  assign full = (q.wr_ptr[PW] != q.rd_ptr[PW]) && (q.wr_ptr[PW-1:0] == q.rd_ptr[PW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rd_ptr[PW-1:0]];

  always_comb
  begin
    next_q = q;
    if (in_valid && !full)
    begin
      next_q.mem[q.wr_ptr[PW-1:0]] = in_data;
      next_q.wr_ptr = q.wr_ptr + (PW+1)'(1);
    end
    if (out_ready && !empty)
      next_q.rd_ptr = q.rd_ptr + (PW+1)'(1);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      q <= '0;
    else if (ce)
      q <= next_q;
  end
endmodule : lcc_fifo
`default_nettype wire

// ==== rtl/lcc_pkg.sv ====
// Constants shared by the LCD command decoder and its helpers
`default_nettype none
package lcc_pkg;
  localparam int DATA_W = 8;
  localparam int LINE_W = 6;
  localparam int PAGE_W = 4;
  localparam int COL_W = 8;
  localparam int WORD_W = DATA_W + 2;
  localparam int FIFO_DEPTH = 8;
  // Host bus modes
  localparam logic [1:0] MODE_8080 = 2'h0;
  localparam logic [1:0] MODE_6800 = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;
  // Address limits
  localparam logic [PAGE_W-1:0] PAGE_INDICATOR = 4'h8;
  localparam logic [COL_W-1:0] COL_LIMIT = 8'h84;
  // Status byte fields
  localparam int ST_BUSY = 7;
  localparam int ST_SEG = 6;
  localparam int ST_OFF = 5;
  localparam int ST_RESET = 4;
  // Queue word fields
  localparam int WD_READ = DATA_W + 1;
  localparam int WD_RS = DATA_W;
  // Command patterns
  localparam logic [6:0] CMD_DISP_ONOFF = 7'h57;
  localparam logic [6:0] CMD_SEG_ORDER = 7'h50;
  localparam logic [6:0] CMD_POLARITY = 7'h53;
  localparam logic [6:0] CMD_ALL_ON = 7'h52;
  localparam logic [6:0] CMD_BIAS = 7'h51;
  localparam logic [1:0] CMD_START_LINE = 2'h1;
  localparam logic [3:0] CMD_PAGE = 4'hB;
  localparam logic [3:0] CMD_COL_HI = 4'h1;
  localparam logic [3:0] CMD_COL_LO = 4'h0;
  localparam logic [7:0] CMD_RMW = 8'hE0;
  localparam logic [7:0] CMD_END = 8'hEE;
  localparam logic [7:0] CMD_RESET = 8'hE2;
  // Initialisation time
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_TIME_NS = 1000;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = $clog2(RESET_CYCLES + 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_INIT = RST_CNT_W'(RESET_CYCLES);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = '0;
endpackage : lcc_pkg
`default_nettype wire

// ==== rtl/lcc_serial_rx.sv ====
// Serial byte receiver, most significant bit first
`default_nettype none
module lcc_serial_rx
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Serial pins
  input wire logic enable,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic reg_select,
  // Assembled byte
  output logic byte_valid,
  output logic byte_rs,
  output logic [DATA_W-1:0] byte_data
);
  typedef struct packed {
    logic sclk_q;
    logic [2:0] count;
    logic [DATA_W-1:0] shift;
    logic valid;
    logic rs;
  } lcc_ser_t;

  lcc_ser_t q;
  lcc_ser_t next_q;

  assign byte_valid = q.valid;
  assign byte_rs = q.rs;
  assign byte_data = q.shift;

  always_comb
  begin
    next_q = q;
    next_q.valid = 1'b0;
    next_q.sclk_q = sclk;
    if (!enable || cs_n)
      next_q.count = 3'h0;
    else if (sclk && !q.sclk_q)
    begin
      next_q.shift = {q.shift[DATA_W-2:0], sdata};
      next_q.count = q.count + 3'h1;
      if (q.count == 3'h7)
      begin
        next_q.valid = 1'b1;
        next_q.rs = reg_select;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      q <= '0;
    else if (ce)
      q <= next_q;
  end
endmodule : lcc_serial_rx
`default_nettype wire

// ==== tb/lcc_cmd_decoder_monitor.sv ====
// Port-level checker for the LCD command decoder
`default_nettype none
module lcc_cmd_monitor
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Host side
  input wire logic [1:0] bus_mode,
  input wire logic cs_n,
  input wire logic rd_e,
  input wire logic data_oe,
  // RAM side
  input wire logic [PAGE_W-1:0] ram_page,
  input wire logic [COL_W-1:0] ram_col,
  input wire logic [DATA_W-1:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  // State
  input wire logic display_on,
  input wire logic all_on,
  input wire logic power_save,
  input wire logic [PAGE_W-1:0] page,
  input wire logic [COL_W-1:0] column,
  input wire logic rmw_active,
  input wire logic busy,
  input wire logic reset_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [COL_W-1:0] saved_col;

  // Column last seen outside read-modify-write
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      saved_col <= '0;
    else if (!rmw_active)
      saved_col <= column;

  chk_power_save: assert property (($stable(all_on) && $stable(display_on))[*2]
    |-> power_save == (all_on && !display_on)) else $error("power save mismatch");
  chk_reset_busy: assert property (reset_active |-> busy)
    else $error("busy low during init");
  chk_init_span: assert property ($rose(reset_active) |=> reset_active[*8])
    else $error("init too short");
  chk_we_pulse: assert property (ram_we ##1 ram_we
    |-> ram_col != $past(ram_col) || ram_col == COL_LIMIT)
    else $error("write repeated at one column");
  chk_col_advance: assert property (ram_we
    |-> column == ((ram_col < COL_LIMIT) ? ram_col + 8'h01 : COL_LIMIT))
    else $error("column not advanced");
  chk_page_steady: assert property (ram_we || ram_re |-> ram_page == page)
    else $error("page moved on access");
  chk_ind_bits: assert property (ram_we && ram_page == PAGE_INDICATOR
    |-> ram_wdata[7:1] == 7'h00) else $error("indicator page upper bits");
  chk_rmw_read: assert property (ram_re && rmw_active |-> column == ram_col)
    else $error("column moved on rmw read");
  chk_end_restore: assert property ($fell(rmw_active) && !reset_active
    |-> column == saved_col) else $error("column not restored");
  chk_serial_read: assert property (bus_mode == MODE_SERIAL
    && $past(bus_mode) == MODE_SERIAL |-> !data_oe && !ram_re)
    else $error("data read in serial mode");
  chk_oe_follow: assert property (bus_mode == MODE_8080 && !cs_n && !rd_e
    |=> data_oe) else $error("output enable missing");

  cover property (ram_we && ram_page == PAGE_INDICATOR);
  cover property ($fell(rmw_active));
  cover property (power_save);
  cover property (ram_re);
endmodule : lcc_cmd_monitor
`default_nettype wire

// ==== tb/lcc_cmd_decoder_tb.sv ====
// Self-checking testbench for the LCD command decoder
`default_nettype none
module lcc_cmd_decoder_tb
  import lcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic hardware_reset_n = 1'b1;
  logic cs_n = 1'b1;
  logic reg_select = 1'b0;
  logic rd_e = 1'b1;
  logic wr_rw = 1'b1;
  logic sclk = 1'b0;
  logic sdata = 1'b0;
  logic stall = 1'b0;
  logic [1:0] bus_mode = MODE_8080;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, ram_rdata, ram_wdata, ram_col, column, rv, modes;
  logic data_oe, ram_ready, ram_we, ram_re, display_on, seg_reverse, reverse_video;
  logic all_on, bias_sel, power_save, rmw_active, busy, reset_active;
  logic [3:0] ram_page, page;
  logic [5:0] start_line;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] mcmd [0:10] = '{8'hA3, 8'hA7, 8'hA5, 8'hAF, 8'hA1, 8'hAE,
    8'hA4, 8'hA6, 8'hA0, 8'hA2, 8'hAF};
  logic [7:0] mexp [0:10] = '{8'h01, 8'h05, 8'h27, 8'h17, 8'h1F, 8'h2F,
    8'h0D, 8'h09, 8'h01, 8'h00, 8'h10};

  assign modes = {2'h0, power_save, display_on, seg_reverse, reverse_video, all_on, bias_sel};

  always #2 clk_sys = ~clk_sys;

  lcc_cmd_decoder i_lcc_cmd_decoder (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .hardware_reset_n(hardware_reset_n),
    .bus_mode(bus_mode),
    .cs_n(cs_n),
    .reg_select(reg_select),
    .rd_e(rd_e),
    .wr_rw(wr_rw),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .sclk(sclk),
    .sdata(sdata),
    .ram_ready(ram_ready),
    .ram_rdata(ram_rdata),
    .ram_page(ram_page),
    .ram_col(ram_col),
    .ram_wdata(ram_wdata),
    .ram_we(ram_we),
    .ram_re(ram_re),
    .display_on(display_on),
    .seg_reverse(seg_reverse),
    .reverse_video(reverse_video),
    .all_on(all_on),
    .bias_sel(bias_sel),
    .power_save(power_save),
    .start_line(start_line),
    .page(page),
    .column(column),
    .rmw_active(rmw_active),
    .busy(busy),
    .reset_active(reset_active)
  );

  lcc_ram_model i_lcc_ram_model (
    .clk_sys(clk_sys),
    .stall(stall),
    .ram_page(ram_page),
    .ram_col(ram_col),
    .ram_wdata(ram_wdata),
    .ram_we(ram_we),
    .ram_re(ram_re),
    .ram_ready(ram_ready),
    .ram_rdata(ram_rdata)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic rs, input logic [7:0] d);
    @(posedge clk_sys);
    reg_select <= rs;
    data_in <= d;
    wr_rw <= 1'b0;
    @(posedge clk_sys);
    wr_rw <= 1'b1;
    cyc(6);
  endtask : wr

  task automatic rd(input logic rs, output logic [7:0] d);
    @(posedge clk_sys);
    reg_select <= rs;
    rd_e <= 1'b0;
    cyc(2);
    @(negedge clk_sys);
    d = data_out;
    @(posedge clk_sys);
    rd_e <= 1'b1;
    cyc(6);
  endtask : rd

  // 6800 cycle: enable high pulse, direction on wr_rw, taken at enable fall
  task automatic e68(input logic rs, input logic rw, input logic [7:0] di,
    output logic [7:0] d);
    @(posedge clk_sys);
    reg_select <= rs;
    wr_rw <= rw;
    data_in <= di;
    rd_e <= 1'b1;
    cyc(2);
    @(negedge clk_sys);
    d = data_out;
    @(posedge clk_sys);
    rd_e <= 1'b0;
    cyc(6);
  endtask : e68

  task automatic ser(input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    bus_mode <= MODE_SERIAL;
    reg_select <= 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      @(posedge clk_sys);
      sdata <= d[i];
      sclk <= 1'b0;
      cyc(2);
      sclk <= 1'b1;
    end
    cyc(2);
    sclk <= 1'b0;
    sdata <= ~d[0];
    cyc(6);
  endtask : ser

  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++)
      @(negedge clk_sys);
    chk("busy", 8'h00, {7'h00, busy});
  endtask : wait_idle

  initial
  begin
    cyc(6000);
    n_errors++;
    end_of_test();
  end

  initial
  begin
    cyc(12);
    nrst <= 1'b1;
    cs_n <= 1'b0;
    cyc(2);
    rd(1'b0, rv);
    chk("status_init", 8'hF0, rv);
    wait_idle();
    rd(1'b0, rv);
    chk("status_idle", 8'h60, rv);
    for (int i = 0; i < 11; i++)
    begin
      wr(1'b0, mcmd[i]);
      chk("modes", mexp[i], modes);
    end
    rd(1'b0, rv);
    chk("status_on", 8'h40, rv);
    wr(1'b0, 8'hA1);
    rd(1'b0, rv);
    chk("status_seg", 8'h00, rv);
    wr(1'b0, 8'hA0);
    wr(1'b0, 8'h6A);
    wr(1'b0, 8'hB3);
    wr(1'b0, 8'hB9);
    wr(1'b0, 8'hD3);
    chk("line", 8'h2A, {2'h0, start_line});
    chk("page", 8'h03, {4'h0, page});
    chk("column", 8'h00, column);
    wr(1'b0, 8'h10);
    wr(1'b0, 8'h05);
    stall <= 1'b1;
    wr(1'b1, 8'h11);
    cyc(10);
    stall <= 1'b0;
    wr(1'b1, 8'h22);
    chk("mem35", 8'h11, i_lcc_ram_model.mem[3][5]);
    chk("mem36", 8'h22, i_lcc_ram_model.mem[3][6]);
    chk("col_wr", 8'h07, column);
    wr(1'b0, 8'h05);
    rd(1'b1, rv);
    rd(1'b1, rv);
    chk("rd5", 8'h11, rv);
    rd(1'b1, rv);
    chk("rd6", 8'h22, rv);
    wr(1'b0, 8'h05);
    wr(1'b0, 8'hE0);
    rd(1'b1, rv);
    rd(1'b1, rv);
    chk("rmw_rd", 8'h11, rv);
    chk("rmw_col", 8'h05, column);
    wr(1'b1, 8'h33);
    chk("rmw_wcol", 8'h06, column);
    wr(1'b0, 8'hEE);
    chk("end_col", 8'h05, column);
    chk("rmw_off", 8'h00, {7'h00, rmw_active});
    wr(1'b0, 8'h18);
    wr(1'b0, 8'h03);
    chk("col_max", 8'h83, column);
    wr(1'b1, 8'hAA);
    wr(1'b1, 8'hBB);
    chk("col_end", 8'h84, column);
    chk("mem131", 8'hAA, i_lcc_ram_model.mem[3][131]);
    wr(1'b0, 8'hB8);
    wr(1'b0, 8'h10);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'hFF);
    chk("ind", 8'h01, i_lcc_ram_model.mem[8][0]);
    ser(8'hB2);
    chk("ser_page", 8'h02, {4'h0, page});
    rd(1'b1, rv);
    chk("ser_rd", 8'h01, column);
    bus_mode <= MODE_8080;
    wr(1'b0, 8'hE2);
    rd(1'b0, rv);
    chk("st_reset", 8'hD0, rv);
    wr(1'b0, 8'hB5);
    wait_idle();
    chk("busy_drop", 8'h00, {4'h0, page});
    chk("line_clr", 8'h00, {2'h0, start_line});
    hardware_reset_n <= 1'b0;
    cyc(4);
    hardware_reset_n <= 1'b1;
    wait_idle();
    chk("hw_reset", 8'h00, modes);
    bus_mode <= MODE_6800;
    e68(1'b0, 1'b0, 8'hB4, rv);
    chk("page_6800", 8'h04, {4'h0, page});
    e68(1'b0, 1'b1, 8'h00, rv);
    chk("status_6800", 8'h60, rv);
    end_of_test();
  end
endmodule : lcc_cmd_decoder_tb

bind lcc_cmd_decoder lcc_cmd_monitor i_lcc_cmd_monitor (.*);
`default_nettype wire

// ==== tb/lcc_ram_model.sv ====
// Display RAM model on the decoder's memory port
`default_nettype none
module lcc_ram_model
  import lcc_pkg::*;
(
  // Clock and stall control
  input wire logic clk_sys,
  input wire logic stall,
  // Access
  input wire logic [PAGE_W-1:0] ram_page,
  input wire logic [COL_W-1:0] ram_col,
  input wire logic [DATA_W-1:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  // Answer
  output logic ram_ready,
  output logic [DATA_W-1:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:8][0:132];

  assign ram_ready = !stall;

  initial ram_rdata = 8'h5A;

  // Read data valid one cycle, then toggles
  always @(posedge clk_sys)
  begin
    ram_rdata <= ~ram_rdata;
    if (ram_we)
      mem[ram_page][ram_col] <= ram_wdata;
    if (ram_re)
      ram_rdata <= mem[ram_page][ram_col];
  end
endmodule : lcc_ram_model
`default_nettype wire
